// >>> pkg/afh_pkg.sv
// Purpose: Shared constants and types for the flash host bus port controller.
// Assumes: A 10 MHz system clock; flash pins are sampled synchronously to it.
// Notes:   Pin timing figures are conservative defaults and may be tuned per part.

package afh_pkg;

    // ****************************************************************
    // Clock and pin timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETUP_NS      = 100;
    localparam int STROBE_NS     = 150;
    localparam int HOLD_NS       = 50;
    localparam int RESET_NS      = 1000;
    localparam int WAKE_NS       = 1000;

    // Least times round up, and no phase lasts less than one cycle.
    function automatic int afh_min_cycles(input int ns);
        int cyc;
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam int SETUP_CYC  = afh_min_cycles(SETUP_NS);
    localparam int STROBE_CYC = afh_min_cycles(STROBE_NS);
    localparam int HOLD_CYC   = afh_min_cycles(HOLD_NS);
    localparam int RESET_CYC  = afh_min_cycles(RESET_NS);
    localparam int WAKE_CYC   = afh_min_cycles(WAKE_NS);

    // ****************************************************************
    // Widths and register map
    // ****************************************************************
    localparam int ADDR_WIDTH = 24;
    localparam int DATA_WIDTH = 16;
    localparam int CNT_WIDTH  = 16;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_WDATA  = 8'h08;
    localparam logic [7:0] OFF_RDATA  = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CMD    = 8'h14;

    localparam int CTRL_WORD_BIT   = 0;
    localparam int CTRL_SINGLE_BIT = 1;
    localparam int CTRL_PROG_BIT   = 2;
    localparam int CTRL_RESET_BIT  = 3;
    localparam logic [3:0] CTRL_RESET_VALUE = 4'h0;

    localparam int CMD_READ_BIT  = 0;
    localparam int CMD_WRITE_BIT = 1;

    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_READY_BIT = 2;
    localparam int STAT_RESET_BIT = 3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    localparam logic [15:0] BYTE_LANE_MASK = 16'h00FF;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic chipSelectThird;
        logic chipSelectSecond;
        logic chipSelectFirst;
        logic outputDriveN;
        logic writeStrobeN;
        logic resetPowerdownN;
        logic wordWidthSel;
        logic programEnable;
    } afh_pins_type;

    // Deselected, both strobes idle, reset/power-down asserted.
    localparam afh_pins_type PINS_RESET = 8'hF8;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_WAKE,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } afh_state_type;

endpackage

// >>> design/afh_host_port.sv
// Purpose: Host controller that runs asynchronous read and write cycles on a parallel flash port.
// Assumes: Software drives it over AHB-Lite; the status pin has an external pull-up.
// Notes:   One flash cycle at a time; commands arriving while busy are dropped.

`timescale 1ns/1ps

module afh_host_port #(
    parameter int ADDR_W     = afh_pkg::ADDR_WIDTH,
    parameter int DATA_W     = afh_pkg::DATA_WIDTH,
    parameter int SETUP_CYC  = afh_pkg::SETUP_CYC,
    parameter int STROBE_CYC = afh_pkg::STROBE_CYC,
    parameter int HOLD_CYC   = afh_pkg::HOLD_CYC,
    parameter int RESET_CYC  = afh_pkg::RESET_CYC,
    parameter int WAKE_CYC   = afh_pkg::WAKE_CYC
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // Flash control pins
    output afh_pkg::afh_pins_type     flashPins,
    output logic [ADDR_W-1:0]         addressLines,
    // Flash data lines, split into input, output and enable
    input  wire logic [DATA_W-1:0]    dataLinesIn,
    output logic [DATA_W-1:0]         dataLinesOut,
    output logic [DATA_W-1:0]         dataLinesOe,
    // Flash status pin, open drain with external pull-up
    input  wire logic                 statusPin
);

    localparam int CW = afh_pkg::CNT_WIDTH;

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic              wrPend_reg;
    logic [7:0]        wrAddr_reg;
    logic [3:0]        ctrl_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              done_reg;
    logic              ready_reg;
    afh_pkg::afh_state_type state_reg;
    afh_pkg::afh_state_type state_next;
    logic [CW-1:0]     cnt_reg;
    logic [CW-1:0]     cnt_next;
    logic              isWrite_reg;

    wire        addrPhase  = hsel && hready && (htrans == afh_pkg::HTRANS_NONSEQ);
    wire [7:0]  rdOffset   = haddr[7:0];
    wire        ctrlWrite  = wrPend_reg && (wrAddr_reg == afh_pkg::OFF_CTRL);
    wire        addrWrite  = wrPend_reg && (wrAddr_reg == afh_pkg::OFF_ADDR);
    wire        wdataWrite = wrPend_reg && (wrAddr_reg == afh_pkg::OFF_WDATA);
    wire        statWrite  = wrPend_reg && (wrAddr_reg == afh_pkg::OFF_STATUS);
    wire        cmdWrite   = wrPend_reg && (wrAddr_reg == afh_pkg::OFF_CMD);
    wire        wordMode   = ctrl_reg[afh_pkg::CTRL_WORD_BIT];
    wire        singleSel  = ctrl_reg[afh_pkg::CTRL_SINGLE_BIT];
    wire        resetReq   = ctrl_reg[afh_pkg::CTRL_RESET_BIT];
    wire        inReset    = (state_reg == afh_pkg::ST_RESET) || (state_reg == afh_pkg::ST_WAKE);
    wire        busy       = state_reg != afh_pkg::ST_IDLE;
    wire [3:0]  statusWord = {inReset, ready_reg, done_reg, busy};
    wire        doneEvent  = (state_reg == afh_pkg::ST_HOLD) && (cnt_reg == '0);
    wire        doneClear  = statWrite && hwdata[afh_pkg::STAT_DONE_BIT];

    wire [31:0] readValue =
        (rdOffset == afh_pkg::OFF_CTRL)   ? {28'h0000000, ctrl_reg} :
        (rdOffset == afh_pkg::OFF_ADDR)   ? 32'(addr_reg) :
        (rdOffset == afh_pkg::OFF_WDATA)  ? 32'(wdata_reg) :
        (rdOffset == afh_pkg::OFF_RDATA)  ? 32'(rdata_reg) :
        (rdOffset == afh_pkg::OFF_STATUS) ? {28'h0000000, statusWord} :
        32'h00000000;

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= afh_pkg::HRESP_OKAY;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            wrAddr_reg <= haddr[7:0];
            hrdata     <= (addrPhase && !hwrite) ? readValue : hrdata;
            hreadyout  <= 1'b1;
            hresp      <= afh_pkg::HRESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg  <= afh_pkg::CTRL_RESET_VALUE;
            addr_reg  <= '0;
            wdata_reg <= '0;
            done_reg  <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            ctrl_reg  <= ctrlWrite ? hwdata[3:0] : ctrl_reg;
            addr_reg  <= addrWrite ? hwdata[ADDR_W-1:0] : addr_reg;
            wdata_reg <= wdataWrite ? hwdata[DATA_W-1:0] : wdata_reg;
            // A completion in the same cycle as the clear keeps the flag set.
            done_reg  <= doneEvent || (done_reg && !doneClear);
            // The pin is only ever pulled low by the device; high means ready.
            ready_reg <= statusPin;
        end
    end

    // ****************************************************************
    // Flash cycle sequencer
    // ****************************************************************
    wire startRead  = cmdWrite && hwdata[afh_pkg::CMD_READ_BIT] && !resetReq;
    wire startWrite = cmdWrite && hwdata[afh_pkg::CMD_WRITE_BIT] && !resetReq;
    wire startAny   = (state_reg == afh_pkg::ST_IDLE) && (startRead || startWrite);
    wire cntZero    = cnt_reg == '0;
    wire [CW-1:0] cntDec = cntZero ? '0 : cnt_reg - 1'b1;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cntDec;
        unique case (state_reg)
            afh_pkg::ST_RESET: begin
                if (cntZero && !resetReq) begin
                    state_next = afh_pkg::ST_WAKE;
                    cnt_next   = CW'(WAKE_CYC - 1);
                end
            end
            afh_pkg::ST_WAKE: begin
                if (resetReq) begin
                    state_next = afh_pkg::ST_RESET;
                    cnt_next   = CW'(RESET_CYC - 1);
                end else if (cntZero) begin
                    state_next = afh_pkg::ST_IDLE;
                end
            end
            afh_pkg::ST_IDLE: begin
                if (resetReq) begin
                    state_next = afh_pkg::ST_RESET;
                    cnt_next   = CW'(RESET_CYC - 1);
                end else if (startAny) begin
                    state_next = afh_pkg::ST_SETUP;
                    cnt_next   = CW'(SETUP_CYC - 1);
                end
            end
            afh_pkg::ST_SETUP: begin
                if (cntZero) begin
                    state_next = afh_pkg::ST_STROBE;
                    cnt_next   = CW'(STROBE_CYC - 1);
                end
            end
            afh_pkg::ST_STROBE: begin
                if (cntZero) begin
                    state_next = afh_pkg::ST_HOLD;
                    cnt_next   = CW'(HOLD_CYC - 1);
                end
            end
            afh_pkg::ST_HOLD: begin
                if (cntZero) begin
                    state_next = afh_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // Pin drive, registered so every pin changes on a clock edge
    // ****************************************************************
    wire isWriteNext = startAny ? startWrite : isWrite_reg;
    wire selNext     = (state_next == afh_pkg::ST_SETUP) || (state_next == afh_pkg::ST_STROBE) ||
                       (state_next == afh_pkg::ST_HOLD);
    wire strobeNext  = state_next == afh_pkg::ST_STROBE;
    // Select is all three low; deselect raises the first select only in single mode.
    wire [2:0] csNext = selNext ? 3'b000 : (singleSel ? 3'b001 : 3'b111);
    wire [DATA_W-1:0] laneMask = wordMode ? '1 : DATA_W'(afh_pkg::BYTE_LANE_MASK);
    wire [ADDR_W-1:0] addrNext = wordMode ? {addr_reg[ADDR_W-1:1], 1'b0} : addr_reg;

    afh_pkg::afh_pins_type pinsNext;
    assign pinsNext.chipSelectThird  = csNext[2];
    assign pinsNext.chipSelectSecond = csNext[1];
    assign pinsNext.chipSelectFirst  = csNext[0];
    assign pinsNext.outputDriveN     = !(strobeNext && !isWriteNext);
    assign pinsNext.writeStrobeN     = !(strobeNext && isWriteNext);
    assign pinsNext.resetPowerdownN  = state_next != afh_pkg::ST_RESET;
    assign pinsNext.wordWidthSel     = wordMode;
    assign pinsNext.programEnable    = ctrl_reg[afh_pkg::CTRL_PROG_BIT];

    // Sampled in the last low cycle of the output strobe, before it rises.
    wire captureRead = (state_reg == afh_pkg::ST_STROBE) && cntZero && !isWrite_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg    <= afh_pkg::ST_RESET;
            cnt_reg      <= CW'(RESET_CYC - 1);
            isWrite_reg  <= 1'b0;
            flashPins    <= afh_pkg::PINS_RESET;
            addressLines <= '0;
            dataLinesOut <= '0;
            dataLinesOe  <= '0;
            rdata_reg    <= '0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            isWrite_reg  <= isWriteNext;
            flashPins    <= pinsNext;
            addressLines <= startAny ? addrNext : addressLines;
            dataLinesOut <= startAny ? wdata_reg : dataLinesOut;
            dataLinesOe  <= (selNext && isWriteNext) ? laneMask : '0;
            rdata_reg    <= captureRead ? (dataLinesIn & laneMask) : rdata_reg;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_strobes_exclusive: assert property (!(!flashPins.outputDriveN && !flashPins.writeStrobeN))
        else $error("Output-drive and write strobes are low together.");

    a_read_bus_free: assert property (!flashPins.outputDriveN |-> dataLinesOe == '0 && flashPins.writeStrobeN)
        else $error("Host drives data or write strobe during a read.");

    a_reset_quiet: assert property (!flashPins.resetPowerdownN |->
        dataLinesOe == '0 && flashPins.outputDriveN && flashPins.writeStrobeN)
        else $error("Host is active while reset/power-down is low.");

    a_write_edge_hold: assert property ($rose(flashPins.writeStrobeN) |->
        $stable(addressLines) && $stable(dataLinesOut) && dataLinesOe != '0)
        else $error("Address or data changed at the write strobe rising edge.");

    a_single_select_low: assert property (singleSel && $stable(singleSel) |->
        !flashPins.chipSelectSecond && !flashPins.chipSelectThird)
        else $error("Second or third select high in single-select mode.");

    a_byte_upper_off: assert property (!flashPins.wordWidthSel |-> dataLinesOe[DATA_W-1:8] == '0)
        else $error("Upper data lines driven in byte mode.");

    a_word_low_addr: assert property (flashPins.wordWidthSel && selNext && $past(startAny) |->
        ##1 addressLines[0] == 1'b0)
        else $error("Lowest address bit driven in word mode.");

    a_strobe_selected: assert property ((!flashPins.outputDriveN || !flashPins.writeStrobeN) |->
        {flashPins.chipSelectThird, flashPins.chipSelectSecond, flashPins.chipSelectFirst} == 3'b000)
        else $error("Strobe active while the device is deselected.");

    a_wake_deselect: assert property ($rose(flashPins.resetPowerdownN) |->
        flashPins.chipSelectFirst && flashPins.outputDriveN)
        else $error("Access begun at reset/power-down release.");

    a_done_after_hold: assert property (doneEvent |=> done_reg && state_reg == afh_pkg::ST_IDLE)
        else $error("Completion flag missing after a flash cycle.");

endmodule // afh_host_port

// >>> bench/afh_flash_model.sv
// Purpose: Behavioural model of the parallel flash device seen at the host port pins.
// Assumes: Host pins change only just after rising edges of clk.
// Notes:   Sixteen words of array only; released data lines show a pattern that changes every cycle.

`timescale 1ns/1ps

module afh_flash_model #(
    parameter int BUSY_CYC = 3
) (
    // Clock used only to time internal activity
    input  wire logic                  clk,
    // Pins driven by the host
    input  wire afh_pkg::afh_pins_type pins,
    input  wire logic [23:0]           addressLines,
    input  wire logic [15:0]           dataBus,
    // Pins driven by the device
    output logic      [15:0]           dataOut,
    output logic                       statusPin
);
    // ****************************************************************
    // Select decode, read path and write capture
    // ****************************************************************
    // Sixteen words sit inside the first erase block; block erase is not modelled.
    logic [15:0] memArray [16];
    logic [15:0] noise     = 16'hA5A5;
    logic        prevWs    = 1'b1;
    int          busyCount = 0;

    wire anySel   = pins.chipSelectThird | pins.chipSelectSecond | pins.chipSelectFirst;
    wire enabled  = pins.resetPowerdownN & (!anySel |
                    (pins.chipSelectThird & !(pins.chipSelectSecond & pins.chipSelectFirst)));
    wire [3:0]  wordIdx = addressLines[4:1];
    wire [15:0] wordNow = memArray[wordIdx];
    wire [7:0]  byteNow = addressLines[0] ? wordNow[15:8] : wordNow[7:0];
    wire        drive   = enabled & !pins.outputDriveN & pins.writeStrobeN;
    wire        wordOut = drive & pins.wordWidthSel;

    assign dataOut[7:0]  = drive ? (pins.wordWidthSel ? wordNow[7:0] : byteNow) : noise[7:0];
    assign dataOut[15:8] = wordOut ? wordNow[15:8] : noise[15:8];
    // The pin is open drain, so high only ever comes from the pull-up.
    assign statusPin = (busyCount == 0) || !pins.resetPowerdownN;

    initial begin
        for (int i = 0; i < 16; i++) begin
            memArray[i] = 16'hA000 | 16'(i);
        end
    end

    always @(posedge clk) begin
        noise  <= ~noise;
        prevWs <= pins.writeStrobeN;
        if (!pins.resetPowerdownN) begin
            busyCount <= 0;
        end else if (busyCount > 0) begin
            busyCount <= busyCount - 1;
        end else if (!prevWs && pins.writeStrobeN && enabled && pins.programEnable) begin
            busyCount <= BUSY_CYC;
            if (pins.wordWidthSel) begin
                memArray[wordIdx] <= dataBus;
            end else if (addressLines[0]) begin
                memArray[wordIdx][15:8] <= dataBus[7:0];
            end else begin
                memArray[wordIdx][7:0] <= dataBus[7:0];
            end
        end
    end
endmodule // afh_flash_model

// >>> bench/afh_host_port_tb.sv
// Purpose: Self-checking bench for the flash host port controller.
// Assumes: Single AHB-Lite master; hready is fed back from hreadyout.
// Notes:   Pin-level hazards are watched by a monitor on every clock edge at which a strobe is low.

`timescale 1ns/1ps

module afh_host_port_tb;
    // ****************************************************************
    // Signals, design and device model
    // ****************************************************************
    logic                  clk;
    logic                  reset;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    logic                  hreadyout;
    logic [31:0]           hrdata;
    logic                  hresp;
    afh_pkg::afh_pins_type flashPins;
    logic [23:0]           addressLines;
    logic [15:0]           dataLinesOut;
    logic [15:0]           dataLinesOe;
    logic [15:0]           devOut;
    logic                  statusPin;
    logic                  wordMode;
    logic                  singleMode;
    int                    bad_count = 0;
    int                    cmp_count = 0;
    wire  [15:0]           dataWire = (dataLinesOe & dataLinesOut) | (~dataLinesOe & devOut);

    afh_host_port i_afh_host_port (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .flashPins(flashPins), .addressLines(addressLines),
        .dataLinesIn(dataWire), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .statusPin(statusPin));

    // A long busy time keeps the status pin low across several status reads.
    afh_flash_model #(.BUSY_CYC(20)) i_afh_flash_model (.clk(clk), .pins(flashPins), .addressLines(addressLines),
        .dataBus(dataWire), .dataOut(devOut), .statusPin(statusPin));

    always #50 clk = ~clk;

    // ****************************************************************
    // Checks and bus tasks
    // ****************************************************************
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t pin condition broken", $time);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wdat, output logic [31:0] rdat);
        int n;
        n = 0;
        haddr  <= {24'h000000, off};
        htrans <= afh_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n = 100;
        end
        htrans <= 2'h0;
        hwdata <= wdat;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rdat = hrdata;
        if (n >= 100) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        logic [31:0] junk;
        xfer(1'b1, off, d, junk);
    endtask

    task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, off, 32'h00000000, d);
        chk32(d, exp);
        chk32({31'h00000000, hresp}, {31'h00000000, afh_pkg::HRESP_OKAY});
    endtask

    task automatic poll(input logic [31:0] mask, input logic [31:0] want);
        logic [31:0] d;
        int          n;
        n = 0;
        do begin xfer(1'b0, afh_pkg::OFF_STATUS, 32'h00000000, d); n++; end while ((d & mask) !== want && n < 60);
        chk32(d & mask, want);
        if (n >= 60) begin
            wrap_up();
        end
    endtask

    // One flash cycle; a read is compared with the expected data.
    task automatic flash_op(input logic isWrite, input logic [23:0] a, input logic [15:0] d);
        wr(afh_pkg::OFF_ADDR, {8'h00, a});
        wr(afh_pkg::OFF_WDATA, {16'h0000, d});
        wr(afh_pkg::OFF_CMD, isWrite ? 32'h00000002 : 32'h00000001);
        poll(32'h00000003, 32'h00000002);
        wr(afh_pkg::OFF_STATUS, 32'h00000002);
        if (!isWrite) begin
            rd_chk(afh_pkg::OFF_RDATA, {16'h0000, d});
        end
    endtask

    always @(posedge clk) begin
        if (!reset && (!flashPins.outputDriveN || !flashPins.writeStrobeN)) begin
            chk1(flashPins.outputDriveN | flashPins.writeStrobeN);
            chk1(flashPins.resetPowerdownN);
            chk1(!singleMode || !(flashPins.chipSelectSecond | flashPins.chipSelectThird));
            chk1(flashPins.outputDriveN || dataLinesOe === 16'h0000);
            chk1(flashPins.writeStrobeN || dataLinesOe === (wordMode ? 16'hFFFF : afh_pkg::BYTE_LANE_MASK));
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0; reset = 1'b1; hsel = 1'b1; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h00000000; wordMode = 1'b0; singleMode = 1'b0;
        repeat (8) @(posedge clk);
        chk32({24'h000000, flashPins}, {24'h000000, afh_pkg::PINS_RESET});
        reset <= 1'b0;
        poll(32'h00000009, 32'h00000000);
        rd_chk(afh_pkg::OFF_CTRL, 32'h00000000);
        rd_chk(8'h40, 32'h00000000);
        wordMode = 1'b1;
        wr(afh_pkg::OFF_CTRL, 32'h00000005);
        flash_op(1'b1, 24'h000006, 16'hBEEF);
        rd_chk(afh_pkg::OFF_STATUS, 32'h00000000);
        poll(32'h00000004, 32'h00000004);
        flash_op(1'b0, 24'h000006, 16'hBEEF);
        flash_op(1'b0, 24'h000007, 16'hBEEF);
        wordMode = 1'b0;
        wr(afh_pkg::OFF_CTRL, 32'h00000004);
        flash_op(1'b1, 24'h000003, 16'h005A);
        flash_op(1'b0, 24'h000003, 16'h005A);
        flash_op(1'b0, 24'h000002, 16'h0001);
        wordMode = 1'b1;
        wr(afh_pkg::OFF_CTRL, 32'h00000001);
        flash_op(1'b1, 24'h000006, 16'h1234);
        flash_op(1'b0, 24'h000006, 16'hBEEF);
        singleMode = 1'b1;
        wr(afh_pkg::OFF_CTRL, 32'h00000003);
        flash_op(1'b0, 24'h000002, 16'h5A01);
        singleMode = 1'b0;
        wr(afh_pkg::OFF_CTRL, 32'h00000009);
        poll(32'h00000008, 32'h00000008);
        chk32({31'h0, flashPins.resetPowerdownN}, 32'h00000000);
        wr(afh_pkg::OFF_CTRL, 32'h00000001);
        poll(32'h0000000D, 32'h00000004);
        flash_op(1'b0, 24'h000006, 16'hBEEF);
        wrap_up();
    end
endmodule // afh_host_port_tb
